// [src/stb_pkg.sv]
package stb_pkg;
    localparam int STB_CNT_W = 56;
    localparam int STB_WIN_N = 7;
    // Register byte offsets
    localparam logic [7:0] STB_OFS_WIN0 = 8'h00;
    localparam logic [7:0] STB_OFS_SNAP = 8'h1C;
    localparam logic [7:0] STB_OFS_CLKCTL = 8'h20;
    localparam logic [7:0] STB_OFS_CMPCFG = 8'h24;
    localparam logic [7:0] STB_OFS_MATCH0 = 8'h28;
    localparam logic [7:0] STB_OFS_MATCH1 = 8'h2C;
    localparam logic [7:0] STB_OFS_IRQ_STAT = 8'h30;
    localparam logic [7:0] STB_OFS_IRQ_MASK = 8'h34;
    // Clock control fields
    localparam int STB_CLK_DIS_BIT = 0;
    localparam int STB_CLK_SUSP_EN_BIT = 1;
    localparam int STB_CLK_DIV_LSB = 8;
    localparam logic [7:0] STB_CLK_DIV_RST = 8'h02;
    localparam logic [31:0] STB_CLKCTL_RST = 32'h0000_0200;
    // Compare config: start at 8*ch, width minus one at 16+8*ch
    localparam int STB_CMP_START_LSB = 0;
    localparam int STB_CMP_WIDTH_LSB = 16;
    localparam logic [31:0] STB_CMPCFG_RST = 32'h001F_0000 | 32'h1F00_0000;
    localparam logic [1:0] STB_RESP_OKAY = 2'b00;
    localparam logic [1:0] STB_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
    } stb_wreq_t;

    typedef enum logic [2:0] {
        STB_W_IDLE = 3'b001,
        STB_W_EXEC = 3'b010,
        STB_W_RESP = 3'b100
    } stb_wstate_t;
endpackage

// [src/stb_sys_time_base.sv]
`timescale 1ns/10ps
module stb_sys_time_base
    import stb_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_por,
    input wire logic i_wdt_rst,
    input wire logic i_soft_rst,
    input wire logic i_hw_rst,
    input wire logic i_suspend,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_irq,
    output logic [1:0] o_match_pulse
);
    import stb_pkg::*;

    logic [STB_CNT_W-1:0] count;
    logic [23:0] snapshot;
    logic [31:0] clkctl;
    logic [31:0] cmpcfg;
    logic [31:0] match_value_0;
    logic [31:0] match_value_1;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic timer_soft_reset_enable;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    logic clr_count;
    logic [1:0] hit;
    logic [1:0] hit_q;
    logic aw_have;
    logic w_have;
    stb_wreq_t wreq;
    stb_wstate_t wstate;
    logic rd_take;
    logic wstrb_any;
    logic [23:0] count_hi;

    function automatic logic [31:0] win_sel(input logic [STB_CNT_W-1:0] c, input logic [2:0] i);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (i)
            3'd6: r = {8'h00, c[55:32]};
            default: r = c[{i, 2'b00} +: 32];
        endcase
        return r;
    endfunction

    function automatic logic field_hit(input logic [STB_CNT_W-1:0] c, input logic [31:0] v,
                                       input logic [5:0] st, input logic [4:0] wd);
        logic [63:0] sh;
        logic [31:0] mask;
        sh = {8'h00, c} >> st;
        mask = 32'hFFFF_FFFF >> (5'd31 - wd);
        return ((sh[31:0] ^ v) & mask) == 32'h0000_0000;
    endfunction

    // Divider and tick; suspend halts only when allowed
    assign clr_count = i_por | i_wdt_rst | (i_soft_rst & timer_soft_reset_enable);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else if (clr_count || clkctl[STB_CLK_DIS_BIT] ||
                     (i_suspend && clkctl[STB_CLK_SUSP_EN_BIT])) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else if (div_cnt + 1'b1 >= clkctl[STB_CLK_DIV_LSB +: DIV_W]) begin
            div_cnt <= '0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // i_hw_rst deliberately not used here: the count survives it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= '0;
        end else if (clr_count) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

    // Compare
    assign hit[0] = field_hit(count, match_value_0, cmpcfg[STB_CMP_START_LSB +: 6],
                              cmpcfg[STB_CMP_WIDTH_LSB +: 5]);
    assign hit[1] = field_hit(count, match_value_1, cmpcfg[STB_CMP_START_LSB + 8 +: 6],
                              cmpcfg[STB_CMP_WIDTH_LSB + 8 +: 5]);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hit_q <= 2'b00;
            o_match_pulse <= 2'b00;
        end else begin
            hit_q <= hit;
            o_match_pulse <= hit & ~hit_q;
        end
    end

    // Write channel
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            wreq <= '0;
            wstate <= STB_W_IDLE;
            o_bvalid <= 1'b0;
            o_bresp <= STB_RESP_OKAY;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            wstrb_any <= 1'b0;
        end else begin
            case (wstate)
                STB_W_IDLE: begin
                    if (i_awvalid && o_awready) begin
                        aw_have <= 1'b1;
                        o_awready <= 1'b0;
                        wreq.addr <= i_awaddr;
                    end
                    if (i_wvalid && o_wready) begin
                        w_have <= 1'b1;
                        o_wready <= 1'b0;
                        wreq.data <= i_wdata;
                        wstrb_any <= |i_wstrb;
                    end
                    if (aw_have && w_have) begin
                        wstate <= STB_W_EXEC;
                    end
                end
                STB_W_EXEC: begin
                    aw_have <= 1'b0;
                    w_have <= 1'b0;
                    o_bvalid <= 1'b1;
                    o_bresp <= (wreq.addr[7:2] > STB_OFS_IRQ_MASK[7:2]) ? STB_RESP_SLVERR
                                                                         : STB_RESP_OKAY;
                    wstate <= STB_W_RESP;
                end
                STB_W_RESP: begin
                    if (i_bready) begin
                        o_bvalid <= 1'b0;
                        o_awready <= 1'b1;
                        o_wready <= 1'b1;
                        wstate <= STB_W_IDLE;
                    end
                end
                default: begin
                    wstate <= STB_W_IDLE;
                    aw_have <= 1'b0;
                    w_have <= 1'b0;
                    o_awready <= 1'b1;
                    o_wready <= 1'b1;
                end
            endcase
        end
    end

    // Control registers; window and snapshot offsets have no write effect
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clkctl <= STB_CLKCTL_RST;
            cmpcfg <= STB_CMPCFG_RST;
            match_value_0 <= 32'h0000_0000;
            match_value_1 <= 32'h0000_0000;
            irq_mask <= 2'b00;
            timer_soft_reset_enable <= 1'b0;
        end else if (wstate == STB_W_EXEC && wstrb_any) begin
            case (wreq.addr)
                STB_OFS_CLKCTL: begin
                    clkctl <= wreq.data;
                    timer_soft_reset_enable <= wreq.data[31];
                end
                STB_OFS_CMPCFG: cmpcfg <= wreq.data;
                STB_OFS_MATCH0: match_value_0 <= wreq.data;
                STB_OFS_MATCH1: match_value_1 <= wreq.data;
                STB_OFS_IRQ_MASK: irq_mask <= wreq.data[1:0];
                default: ;
            endcase
        end
    end

    // Sticky flags, set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_stat <= 2'b00;
            o_irq <= 1'b0;
        end else begin
            if (wstate == STB_W_EXEC && wreq.addr == STB_OFS_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~wreq.data[1:0]) | (hit & ~hit_q);
            end else begin
                irq_stat <= irq_stat | (hit & ~hit_q);
            end
            o_irq <= |(irq_stat & irq_mask);
        end
    end

    // Read channel; valid in suspend too
    assign rd_take = i_arvalid && o_arready;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= STB_RESP_OKAY;
        end else if (rd_take) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= STB_RESP_OKAY;
            if (i_araddr[7:2] < 6'd7) begin
                o_rdata <= win_sel(count, i_araddr[4:2]);
            end else begin
                case (i_araddr)
                    STB_OFS_SNAP: o_rdata <= {8'h00, snapshot};
                    STB_OFS_CLKCTL: o_rdata <= {timer_soft_reset_enable, clkctl[30:0]};
                    STB_OFS_CMPCFG: o_rdata <= cmpcfg;
                    STB_OFS_MATCH0: o_rdata <= match_value_0;
                    STB_OFS_MATCH1: o_rdata <= match_value_1;
                    STB_OFS_IRQ_STAT: o_rdata <= {30'h0, irq_stat};
                    STB_OFS_IRQ_MASK: o_rdata <= {30'h0, irq_mask};
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= STB_RESP_SLVERR;
                    end
                endcase
            end
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    assign count_hi = count[55:32];
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            snapshot <= 24'h00_0000;
        end else if (rd_take && i_araddr[7:2] < 6'd6) begin
            snapshot <= count_hi;
        end
    end

    a_snap_capture: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rd_take && i_araddr[7:2] < 6'd6) |=> snapshot == $past(count_hi))
        else $error("snapshot not captured");
    a_snap_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(rd_take && i_araddr[7:2] < 6'd6) |=> $stable(snapshot))
        else $error("snapshot moved without read");
    a_count_up: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!clr_count && tick) |=> count == $past(count) + 1'b1)
        else $error("count did not step");
    a_count_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        clr_count |=> count == '0)
        else $error("count not cleared");
    a_count_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (clkctl[STB_CLK_DIS_BIT] && !clr_count) |=> ##1 $stable(count))
        else $error("disabled count moved");
    a_hw_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_hw_rst && !clr_count && !tick) |=> count == $past(count))
        else $error("hw reset touched count");
    a_read_answer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rd_take |=> o_rvalid)
        else $error("read not answered");
    a_match_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (hit[0] && !hit_q[0]) |=> irq_stat[0] && o_match_pulse[0])
        else $error("match not flagged");
    a_win_ro: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wstate == STB_W_EXEC && wreq.addr < STB_OFS_CLKCTL) |=> $stable(clkctl))
        else $error("window write had effect");
    a_win_cmp_ro: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wstate == STB_W_EXEC && wreq.addr < STB_OFS_CLKCTL) |=> $stable(cmpcfg))
        else $error("window write changed compare setup");
    a_win_bresp: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wstate == STB_W_EXEC && wreq.addr <= STB_OFS_SNAP) |=> o_bvalid && o_bresp == STB_RESP_OKAY)
        else $error("window write not answered okay");

    // Flag, divider, suspend, soft reset and read answer checks
    a_match_flag1: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (hit[1] && !hit_q[1]) |=> irq_stat[1] && o_match_pulse[1])
        else $error("match one not flagged");
    a_stat_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (irq_stat[0] && !(wstate == STB_W_EXEC && wreq.addr == STB_OFS_IRQ_STAT))
        |=> irq_stat[0])
        else $error("status flag lost");
    a_stat_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (wstate == STB_W_EXEC && wreq.addr == STB_OFS_IRQ_STAT && wreq.data[0] &&
         !(hit[0] && !hit_q[0])) |=> !irq_stat[0])
        else $error("status flag not cleared");
    a_irq_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (|(irq_stat & irq_mask)) |=> o_irq)
        else $error("irq not raised");
    a_irq_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(|(irq_stat & irq_mask)) |=> !o_irq)
        else $error("irq raised without cause");
    a_pulse_once0: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_match_pulse[0] |=> !o_match_pulse[0])
        else $error("match pulse zero too long");
    a_pulse_once1: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_match_pulse[1] |=> !o_match_pulse[1])
        else $error("match pulse one too long");
    a_div_tick: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (tick && clkctl[STB_CLK_DIV_LSB +: DIV_W] > 1) |=> !tick)
        else $error("divided tick too fast");
    a_dis_notick: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        clkctl[STB_CLK_DIS_BIT] |=> !tick)
        else $error("tick while disabled");
    a_susp_halt: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_suspend && clkctl[STB_CLK_SUSP_EN_BIT]) |=> !tick)
        else $error("tick during suspend");
    a_soft_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_soft_rst && !timer_soft_reset_enable && !i_por && !i_wdt_rst) |=> count >= $past(count))
        else $error("soft reset cleared count while not enabled");
    a_read_okay: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rd_take && i_araddr[7:2] < 6'd7) |=> o_rresp == STB_RESP_OKAY)
        else $error("window read not okay");
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
    import stb_pkg::*;
    logic clk = 0, rst_b = 0, susp = 0, awv = 0, wv = 0, arv = 0;
    logic [3:0] rs = 4'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, a;
    logic [1:0] rrsp, brsp, mp, bresp, rresp;
    logic awr, wrdy, bv, arr, rv, irq;
    logic [31:0] rd_bus;
    int n_fail = 0, checked = 0, cyc = 0, rcyc, pc = 0, pc1 = 0;

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (mp[0] === 1'b1) pc <= pc + 1;
    always @(posedge clk) if (mp[1] === 1'b1) pc1 <= pc1 + 1;

    stb_sys_time_base dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_por(rs[0]), .i_wdt_rst(rs[1]),
        .i_soft_rst(rs[2]), .i_hw_rst(rs[3]), .i_suspend(susp), .i_awaddr(awa),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv),
        .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bv), .i_bready(1'b1), .i_araddr(ara),
        .i_arvalid(arv), .o_arready(arr), .o_rdata(rd_bus), .o_rresp(rresp), .o_rvalid(rv),
        .i_rready(1'b1), .o_irq(irq), .o_match_pulse(mp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awa <= ad;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (!ta && awr === 1'b1) begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (!tw && wrdy === 1'b1) begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        brsp = bresp;
    endtask

    task automatic rd(input logic [7:0] ad);
        ara <= ad;
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        rcyc = cyc;
        do @(posedge clk); while (rv !== 1'b1);
        rdat = rd_bus;
        rrsp = rresp;
    endtask

    task automatic rate(input int k);
        int c1;
        rd(STB_OFS_WIN0);
        a = rdat;
        c1 = rcyc;
        repeat (40) @(posedge clk);
        rd(STB_OFS_WIN0);
        chk(32'(k * (rdat - a) + k >= rcyc - c1 && k * (rdat - a) <= rcyc - c1 + k), 32'h1);
    endtask

    task automatic t_regs;
        rd(STB_OFS_CLKCTL);
        chk(rdat, STB_CLKCTL_RST);
        rd(STB_OFS_CMPCFG);
        chk(rdat, STB_CMPCFG_RST);
        rd(8'h40);
        chk(32'(rrsp), 32'(STB_RESP_SLVERR));
        chk(rdat, 32'h0000_0000);
        wr(8'h40, 32'h0000_0001);
        chk(32'(brsp), 32'(STB_RESP_SLVERR));
        rate(2);
        wr(STB_OFS_CLKCTL, 32'h0000_0100);
        rate(1);
        wr(STB_OFS_CLKCTL, 32'h0000_0200);
        $display("test regs and rate done");
    endtask

    task automatic t_win;
        int sh;
        logic [31:0] mid;
        for (int k = 1; k < 7; k++) begin
            sh = (k == 6) ? 32 : 4 * k;
            rd(STB_OFS_WIN0);
            a = rdat;
            rd(8'(STB_OFS_WIN0 + 4 * k));
            mid = rdat;
            rd(STB_OFS_WIN0);
            chk(32'((64'(a) >> sh) <= mid && mid <= (64'(rdat) >> sh)), 32'h1);
        end
        rd(8'(STB_OFS_WIN0 + 20));
        rd(STB_OFS_SNAP);
        chk(rdat, 32'h0000_0000);
        rd(STB_OFS_WIN0);
        a = rdat;
        wr(STB_OFS_WIN0, 32'hFFFF_FFFF);
        chk(32'(brsp), 32'(STB_RESP_OKAY));
        wr(STB_OFS_SNAP, 32'hFFFF_FFFF);
        rd(STB_OFS_WIN0);
        chk(32'(rdat >= a && rdat - a < 32'h0000_0040), 32'h1);
        $display("test windows done");
    endtask

    task automatic t_freeze;
        for (int k = 0; k < 2; k++) begin
            wr(STB_OFS_CLKCTL, k ? 32'h0000_0202 : 32'h0000_0201);
            susp <= k[0];
            rd(STB_OFS_WIN0);
            a = rdat;
            repeat (20) @(posedge clk);
            rd(STB_OFS_WIN0);
            chk(rdat, a);
            rd(STB_OFS_CLKCTL);
            chk(rdat, k ? 32'h0000_0202 : 32'h0000_0201);
        end
        susp <= 1'b0;
        wr(STB_OFS_CLKCTL, 32'h0000_0200);
        $display("test freeze done");
    endtask

    task automatic t_resets;
        logic [3:0] src [5] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'h4};
        for (int k = 0; k < 5; k++) begin
            if (k == 4) wr(STB_OFS_CLKCTL, 32'h8000_0200);
            repeat (60) @(posedge clk);
            rd(STB_OFS_WIN0);
            a = rdat;
            rs <= src[k];
            @(posedge clk);
            rs <= 4'h0;
            @(posedge clk);
            rd(STB_OFS_WIN0);
            if (k < 2) begin
                chk(32'(rdat > a), 32'h1);
            end else begin
                chk(32'(rdat < 32'h0000_0010), 32'h1);
                repeat (6) @(posedge clk);
                rd(STB_OFS_WIN0);
                chk(32'(rdat > 0 && rdat < 32'h0000_0010), 32'h1);
            end
        end
        wr(STB_OFS_CLKCTL, 32'h0000_0200);
        $display("test resets done");
    endtask

    task automatic t_irq;
        wr(STB_OFS_CMPCFG, 32'h0103_0400);
        wr(STB_OFS_MATCH0, 32'h0000_0005);
        wr(STB_OFS_MATCH1, 32'h0000_0002);
        wr(STB_OFS_IRQ_MASK, 32'h0000_0000);
        wr(STB_OFS_IRQ_STAT, 32'h0000_0003);
        repeat (150) @(posedge clk);
        rd(STB_OFS_IRQ_STAT);
        chk(32'(rdat[1:0]), 32'h3);
        chk(32'(irq), 32'h0);
        chk(32'(pc > 0), 32'h1);
        chk(32'(pc1 > 0), 32'h1);
        wr(STB_OFS_IRQ_MASK, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        wr(STB_OFS_CLKCTL, 32'h0000_0201);
        wr(STB_OFS_IRQ_STAT, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        rd(STB_OFS_IRQ_STAT);
        chk(32'(rdat[1:0]), 32'h0);
        wr(STB_OFS_CLKCTL, 32'h0000_0200);
        $display("test compare irq done");
    endtask

    task automatic complete_run;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs;
        t_win;
        t_freeze;
        t_resets;
        t_irq;
        complete_run;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule
